// [rtl/safety_stop_pkg.sv]
// Constants and types shared by the safety stop coordinator
package safety_stop_pkg;

  // Bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_NET_CMD    = 4'h1;
  localparam logic [3:0] REG_IN_ASSIGN  = 4'h2;
  localparam logic [3:0] REG_DECEL_TIME = 4'h3;
  localparam logic [3:0] REG_OUT_ASSIGN = 4'h4;
  localparam logic [3:0] REG_STATUS     = 4'h5;

  // Control register fields
  localparam int CTRL_MODE_BIT  = 0;
  localparam int CTRL_METH_LSB  = 1;
  localparam int CTRL_RESET_BIT = 3;

  // Status register fields
  localparam int STAT_ALARM_BIT = 10;
  localparam int STAT_STOP_BIT  = 11;
  localparam int STAT_FSM_LSB   = 12;

  // Safety sub-functions, one status-monitor bit each
  localparam int NFUNC           = 10;
  localparam int FN_SHUTOFF      = 0;
  localparam int FN_DECEL        = 1;
  localparam int FN_DECEL_HOLD   = 2;
  localparam int FN_STANDSTILL   = 3;
  localparam int FN_SPEED_LIMIT  = 4;
  localparam int FN_TRAVEL_LIMIT = 5;
  localparam int FN_TORQUE_LIMIT = 6;
  localparam int FN_DIRECTION    = 7;
  localparam int FN_BRAKE_CTRL   = 8;
  localparam int FN_SPEED_WINDOW = 9;

  // Pins and assignment codes (code 0 means unassigned)
  localparam int NIN      = 4;
  localparam int NOUT     = 3;
  localparam int CODE_W   = 4;
  localparam logic [CODE_W-1:0] CODE_NONE = 4'h0;

  // Reset values
  localparam logic [NFUNC-1:0]  NET_CMD_RST    = 10'h3ff;
  localparam logic [15:0]       IN_ASSIGN_RST  = 16'h0000;
  localparam logic [11:0]       OUT_ASSIGN_RST = 12'h000;
  localparam logic [15:0]       DECEL_TIME_RST = 16'h03e8;

  // Timing: deceleration monitor counts in microseconds
  localparam int CLK_PERIOD_PS = 8000;
  localparam int TICK_TIME_PS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_PS / CLK_PERIOD_PS;
  localparam int PRESCALE_W    = 7;

  // Controlled-stop sequencer
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DECEL = 2'b01,
    ST_HOLD  = 2'b11
  } stop_state_t;

  // Alarm stop methods
  typedef enum logic [1:0] {
    M_SHUTOFF_DYN  = 2'b00,
    M_DECEL_ELEC   = 2'b01,
    M_DECEL_FORCED = 2'b10
  } method_t;

endpackage : safety_stop_pkg

// [rtl/pin_sync.sv]
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         resetn,
  // Levels
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pin_sync
`default_nettype wire

// [rtl/safety_stop_coordinator.sv]
// Safety sub-function stop coordinator with register port
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module safety_stop_coordinator
  import safety_stop_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESETN,
  // Register port
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output var  logic [DATA_W-1:0] RDATA,
  // Safety pins
  input  wire logic [NIN-1:0]    SAFETY_IN,
  input  wire logic              ALARM_CAUSE,
  input  wire logic              SERIOUS_ERR,
  input  wire logic              COMM_RESET,
  // Status and drive outputs
  output var  logic              TORQUE_SHUTOFF_STATUS,
  output var  logic              MALFUNCTION_ALARM,
  output var  logic [NFUNC-1:0]  STATUS_MON,
  output var  logic [NOUT-1:0]   SAFETY_OUT,
  output var  logic              DYN_BRAKE,
  output var  logic              ELEC_BRAKE,
  output var  logic              FORCED_DECEL
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [NIN+2:0] pins_s;
  logic [NIN-1:0] in_s;
  logic           cause_s;
  logic           serr_s;
  logic           comm_s;
  logic           comm_q;

  pin_sync #(.W(NIN + 3)) u_sync (
    .clk    (CLK),
    .resetn (RESETN),
    .d      ({COMM_RESET, SERIOUS_ERR, ALARM_CAUSE, SAFETY_IN}),
    .q      (pins_s)
  );

  assign in_s    = pins_s[NIN-1:0];
  assign cause_s = pins_s[NIN];
  assign serr_s  = pins_s[NIN+1];
  assign comm_s  = pins_s[NIN+2];

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      comm_q <= 1'b0;
    end else begin
      comm_q <= comm_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic                      net_mode;
  method_t                   method;
  logic [NFUNC-1:0]          net_cmd;
  logic [NIN*CODE_W-1:0]     in_assign;
  logic [15:0]               decel_time;
  logic [NOUT*CODE_W-1:0]    out_assign;
  logic                      wr_ctrl;

  assign wr_ctrl = WR && (ADDR == REG_CTRL);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      net_mode   <= 1'b0;
      method     <= M_SHUTOFF_DYN;
      net_cmd    <= NET_CMD_RST;
      in_assign  <= IN_ASSIGN_RST;
      decel_time <= DECEL_TIME_RST;
      out_assign <= OUT_ASSIGN_RST;
    end else if (WR) begin
      case (ADDR)
        REG_CTRL: begin
          net_mode <= WDATA[CTRL_MODE_BIT];
          method   <= method_t'(WDATA[CTRL_METH_LSB +: 2]);
        end
        REG_NET_CMD:    net_cmd    <= WDATA[NFUNC-1:0];
        REG_IN_ASSIGN:  in_assign  <= WDATA[NIN*CODE_W-1:0];
        REG_DECEL_TIME: decel_time <= WDATA;
        REG_OUT_ASSIGN: out_assign <= WDATA[NOUT*CODE_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic [NFUNC-1:0] cmd_dev;
  logic [NFUNC-1:0] req;
  logic             inputs_ok;

  // Several pins may share one function; any pin off requests it
  always_comb begin
    cmd_dev   = '1;
    inputs_ok = 1'b1;
    for (int p = 0; p < NIN; p++) begin
      if (in_assign[p*CODE_W +: CODE_W] != CODE_NONE) begin
        inputs_ok = inputs_ok & in_s[p];
        for (int f = 0; f < NFUNC; f++) begin
          if (in_assign[p*CODE_W +: CODE_W] == CODE_W'(f + 1)) begin
            cmd_dev[f] = cmd_dev[f] & in_s[p];
          end
        end
      end
    end
  end

  assign req = ~(net_mode ? net_cmd : cmd_dev);

  ////////////////////////////////////////////////////////////////////////////
  // Alarm and serious-error state

  logic alarm;
  logic stopped;
  logic rst_req;
  logic reset_ok;
  logic sto_cmd_req;

  assign sto_cmd_req = req[FN_SHUTOFF];
  assign rst_req     = (wr_ctrl && WDATA[CTRL_RESET_BIT])
                     || (comm_s && !comm_q);
  // Network mode needs the shut-off command back on before a reset takes
  assign reset_ok    = !cause_s && !stopped
                     && (net_mode ? !sto_cmd_req : inputs_ok);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      stopped <= 1'b0;
    end else if (serr_s) begin
      stopped <= 1'b1;
    end
  end

  // Cause wins over a reset arriving in the same cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      alarm <= 1'b0;
    end else if (cause_s || serr_s) begin
      alarm <= 1'b1;
    end else if (rst_req && reset_ok) begin
      alarm <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controlled-stop sequencer and its monitor timer

  stop_state_t           state;
  stop_state_t           next_state;
  logic [PRESCALE_W-1:0] prescale;
  logic                  tick;
  logic [15:0]           timer;
  logic                  alarm_decel;
  logic                  decel_req;
  logic                  sto_active;
  logic                  decel_run;
  logic                  expired;

  assign alarm_decel = alarm && (method != M_SHUTOFF_DYN);
  assign decel_req   = req[FN_DECEL] || alarm_decel;
  assign sto_active  = sto_cmd_req || (state == ST_HOLD)
                     || (alarm && method == M_SHUTOFF_DYN);
  assign decel_run   = (state == ST_DECEL) && !sto_cmd_req;
  assign expired     = decel_run && (timer >= decel_time);
  assign tick        = prescale == PRESCALE_W'(TICK_CYCLES - 1);

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prescale <= '0;
    end else begin
      prescale <= tick ? '0 : prescale + 1'b1;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (decel_req) begin
          next_state = sto_active ? ST_HOLD : ST_DECEL;
        end
      end
      ST_DECEL: begin
        if (!decel_req) begin
          next_state = ST_IDLE;
        end else if (expired) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // Shut-off command release alone does not leave this state
        if (!decel_req) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state <= ST_IDLE;
    end else if (!stopped) begin
      state <= next_state;
    end
  end

  // Timer only clears while idle, so a second trigger cannot restart it
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      timer <= '0;
    end else if (state == ST_IDLE) begin
      timer <= '0;
    end else if (decel_run && tick && !stopped && timer != '1) begin
      timer <= timer + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status monitor and outputs

  logic [NFUNC-1:0] next_status;
  logic [NOUT-1:0]  next_out;
  logic             elec_sel;

  assign elec_sel = alarm && method == M_DECEL_ELEC;

  always_comb begin
    next_status             = req;
    next_status[FN_SHUTOFF] = sto_active;
    next_status[FN_DECEL]   = state != ST_IDLE;
    if (stopped) begin
      next_status = '0;
    end
  end

  always_comb begin
    next_out = '0;
    for (int o = 0; o < NOUT; o++) begin
      for (int f = 0; f < NFUNC; f++) begin
        if (out_assign[o*CODE_W +: CODE_W] == CODE_W'(f + 1)) begin
          next_out[o] = next_status[f];
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      TORQUE_SHUTOFF_STATUS <= 1'b0;
      MALFUNCTION_ALARM     <= 1'b1;
      STATUS_MON            <= '0;
      SAFETY_OUT            <= '0;
    end else begin
      TORQUE_SHUTOFF_STATUS <= !(sto_active || stopped);
      MALFUNCTION_ALARM     <= !alarm;
      STATUS_MON            <= next_status;
      SAFETY_OUT            <= next_out;
    end
  end

  // Electronic brake only under the matching alarm method; else ramp down
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      DYN_BRAKE    <= 1'b0;
      ELEC_BRAKE   <= 1'b0;
      FORCED_DECEL <= 1'b0;
    end else begin
      DYN_BRAKE    <= sto_active || stopped;
      ELEC_BRAKE   <= decel_run && elec_sel && !stopped;
      FORCED_DECEL <= decel_run && !elec_sel && !stopped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      RDATA <= '0;
    end else if (RD) begin
      case (ADDR)
        REG_CTRL:       RDATA <= DATA_W'({method, net_mode});
        REG_NET_CMD:    RDATA <= DATA_W'(net_cmd);
        REG_IN_ASSIGN:  RDATA <= DATA_W'(in_assign);
        REG_DECEL_TIME: RDATA <= decel_time;
        REG_OUT_ASSIGN: RDATA <= DATA_W'(out_assign);
        REG_STATUS:     RDATA <= DATA_W'({state, stopped, alarm, STATUS_MON});
        default:        RDATA <= '0;
      endcase
    end else begin
      RDATA <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  any_trigger_a: assert property (
    (state == ST_IDLE && decel_req && !stopped) |=> state != ST_IDLE)
    else $error("stop request ignored");
  alarm_trigger_a: assert property (
    (alarm_decel && !stopped) |=> state != ST_IDLE)
    else $error("alarm did not start controlled stop");
  single_timer_a: assert property (
    (state == ST_DECEL ##1 state == ST_DECEL) |-> timer >= $past(timer))
    else $error("decel timer restarted");
  alarm_hold_a: assert property (
    (state != ST_IDLE && alarm_decel && !stopped) |=> state != ST_IDLE)
    else $error("controlled stop dropped under alarm");
  no_decel_a: assert property (
    (state == ST_IDLE && decel_req && sto_active && !stopped)
      |=> state == ST_HOLD ##1 !FORCED_DECEL && !ELEC_BRAKE)
    else $error("decel started during shut-off");
  hold_keep_a: assert property (
    (state == ST_HOLD && decel_req) |=> state == ST_HOLD)
    else $error("shut-off hold released early");
  suspend_a: assert property (
    (state == ST_DECEL && sto_cmd_req) |=> timer == $past(timer)
      && !FORCED_DECEL && !ELEC_BRAKE)
    else $error("decel not suspended");
  dyn_alarm_a: assert property (
    (alarm && method == M_SHUTOFF_DYN) |=> !TORQUE_SHUTOFF_STATUS && DYN_BRAKE)
    else $error("alarm shut-off missing");
  elec_brake_a: assert property (
    (decel_run && elec_sel && !stopped) |=> ELEC_BRAKE && !FORCED_DECEL)
    else $error("electronic brake missing");
  forced_decel_a: assert property (
    (decel_run && !elec_sel && !stopped) |=> FORCED_DECEL)
    else $error("forced deceleration missing");
  latch_keep_a: assert property (
    (alarm && !rst_req) |=> alarm)
    else $error("alarm dropped without reset");
  outputs_off_a: assert property (
    stopped |=> SAFETY_OUT == '0 && STATUS_MON == '0 && !TORQUE_SHUTOFF_STATUS)
    else $error("outputs not off after serious error");
  reset_clear_a: assert property (
    (alarm && rst_req && reset_ok && !cause_s && !serr_s)
      |=> !alarm ##1 MALFUNCTION_ALARM)
    else $error("alarm reset not honoured");
  input_gate_a: assert property (
    (alarm && !net_mode && !inputs_ok) |=> alarm)
    else $error("reset with inputs off");
  status_low_a: assert property (
    sto_active |=> !TORQUE_SHUTOFF_STATUS)
    else $error("shut-off status high while shut off");
  alarm_low_a: assert property (
    alarm |=> !MALFUNCTION_ALARM)
    else $error("alarm output high while alarmed");

  decel_to_hold_c: cover property (state == ST_DECEL ##1 state == ST_HOLD);
  suspend_c: cover property (decel_run ##1 state == ST_DECEL && sto_cmd_req);
  reset_c: cover property (alarm ##1 !alarm);
  stop_c: cover property (serr_s ##1 stopped);

endmodule : safety_stop_coordinator
`default_nettype wire

// [dv/safety_io_model.sv]
// Model of the safety input devices and the fault sources
`timescale 1ns/1ps
`default_nettype none
module safety_io_model
  import safety_stop_pkg::*;
(
  // Clock
  input  wire logic           clk,
  // Driven pins
  output var  logic [NIN-1:0] safety_in,
  output var  logic           alarm_cause,
  output var  logic           serious_err,
  output var  logic           comm_reset
);
  ////////////////////////////////////////////////////////////////////////////
  // Pins 2 and 3 start off: unassigned they must never block; pin 2 gets a code late in the run
  initial begin
    safety_in   = 4'h3;
    alarm_cause = 1'h0;
    serious_err = 1'h0;
    comm_reset  = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Active-low commands: a low pin requests its function
  task pins(input logic [NIN-1:0] v);
    @(posedge clk);
    safety_in <= v;
  endtask : pins
  // The inputs named in used are turned on before a reset is asked for
  task all_on(input logic [NIN-1:0] used);
    @(posedge clk);
    safety_in <= safety_in | used;
  endtask : all_on
  task fault(input logic c, input logic s);
    @(posedge clk);
    alarm_cause <= c;
    serious_err <= s;
  endtask : fault
  // Held for several cycles so the synchroniser cannot miss it
  task comm_pulse();
    @(posedge clk);
    comm_reset <= 1'h1;
    repeat (4) @(posedge clk);
    comm_reset <= 1'h0;
  endtask : comm_pulse
endmodule : safety_io_model
`default_nettype wire

// [dv/tb_safety_stop_coordinator.sv]
// Self-checking bench for the safety stop coordinator
`timescale 1ns/1ps
`default_nettype none
module tb_safety_stop_coordinator import safety_stop_pkg::*;;
  logic              clk    = 1'h0;
  logic              resetn = 1'h0;
  logic [ADDR_W-1:0] addr   = 4'h0;
  logic [DATA_W-1:0] wdata  = 16'h0;
  logic              wr     = 1'h0;
  logic              rd     = 1'h0;
  logic [DATA_W-1:0] rdata;
  logic [NIN-1:0]    safety_in;
  logic              alarm_cause;
  logic              serious_err;
  logic              comm_reset;
  logic              tss;
  logic              alarm;
  logic              dyn;
  logic              elec;
  logic              forced;
  logic [NFUNC-1:0]  mon;
  logic [NOUT-1:0]   sout;
  int                n_errors   = 0;
  int                num_checks = 0;
  int                cycles     = 0;

  always #4 clk = ~clk;

  safety_stop_coordinator safety_stop_coordinator_i (
    .CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .SAFETY_IN(safety_in),
    .ALARM_CAUSE(alarm_cause), .SERIOUS_ERR(serious_err),
    .COMM_RESET(comm_reset), .TORQUE_SHUTOFF_STATUS(tss),
    .MALFUNCTION_ALARM(alarm), .STATUS_MON(mon), .SAFETY_OUT(sout),
    .DYN_BRAKE(dyn), .ELEC_BRAKE(elec), .FORCED_DECEL(forced));

  safety_io_model safety_io_model_i (
    .clk(clk), .safety_in(safety_in), .alarm_cause(alarm_cause),
    .serious_err(serious_err), .comm_reset(comm_reset));

  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] e);
    num_checks++;
    if (seen !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task put(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    cyc(3);
  endtask : put
  // Read data stand only in the cycle after the strobe
  task rchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk("rdata", rdata, e);
  endtask : rchk
  task conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // The whole run needs about 1500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    cyc(2);
    chk("tss", tss, 16'h1);
    chk("alarm", alarm, 16'h1);
    rchk(REG_NET_CMD, 16'h03ff);
    rchk(REG_DECEL_TIME, 16'h03e8);
    rchk(4'hf, 16'h0000);
    // Network mode, immediate shut-off on alarm
    put(REG_CTRL, 16'h0001);
    put(REG_DECEL_TIME, 16'h0003);
    safety_io_model_i.fault(1'h1, 1'h0);
    cyc(5);
    chk("alarm", alarm, 16'h0);
    chk("tss", tss, 16'h0);
    chk("dyn", dyn, 16'h1);
    put(REG_CTRL, 16'h0009);
    chk("alarm", alarm, 16'h0);
    safety_io_model_i.fault(1'h0, 1'h0);
    cyc(5);
    chk("tss", tss, 16'h0);
    put(REG_NET_CMD, 16'h03fe);
    put(REG_CTRL, 16'h0009);
    chk("alarm", alarm, 16'h0);
    put(REG_NET_CMD, 16'h03ff);
    put(REG_CTRL, 16'h0009);
    chk("alarm", alarm, 16'h1);
    chk("tss", tss, 16'h1);
    // Shut-off during deceleration freezes the timer
    put(REG_NET_CMD, 16'h03fd);
    chk("forced", forced, 16'h1);
    chk("mon", mon, 16'h0002);
    put(REG_NET_CMD, 16'h03fc);
    cyc(400);
    chk("forced", forced, 16'h0);
    put(REG_NET_CMD, 16'h03fd);
    chk("forced", forced, 16'h1);
    cyc(400);
    chk("tss", tss, 16'h0);
    rchk(REG_STATUS, 16'h3003);
    put(REG_NET_CMD, 16'h03ff);
    chk("tss", tss, 16'h1);
    // Stop requested while already shut off
    put(REG_NET_CMD, 16'h03fe);
    put(REG_NET_CMD, 16'h03fc);
    chk("forced", forced, 16'h0);
    rchk(REG_STATUS, 16'h3003);
    put(REG_NET_CMD, 16'h03fd);
    chk("tss", tss, 16'h0);
    put(REG_NET_CMD, 16'h03ff);
    chk("tss", tss, 16'h1);
    // Late alarm must not restart the running timer
    put(REG_CTRL, 16'h0005);
    put(REG_NET_CMD, 16'h03fd);
    cyc(200);
    safety_io_model_i.fault(1'h1, 1'h0);
    cyc(5);
    chk("forced", forced, 16'h1);
    chk("elec", elec, 16'h0);
    chk("alarm", alarm, 16'h0);
    cyc(200);
    chk("tss", tss, 16'h0);
    safety_io_model_i.fault(1'h0, 1'h0);
    put(REG_NET_CMD, 16'h03ff);
    put(REG_CTRL, 16'h000d);
    chk("alarm", alarm, 16'h1);
    chk("tss", tss, 16'h1);
    // Command withdrawn while the alarm still holds the stop
    put(REG_CTRL, 16'h0003);
    put(REG_NET_CMD, 16'h03fd);
    safety_io_model_i.fault(1'h1, 1'h0);
    cyc(5);
    put(REG_NET_CMD, 16'h03ff);
    chk("mon", mon, 16'h0002);
    chk("elec", elec, 16'h1);
    safety_io_model_i.fault(1'h0, 1'h0);
    cyc(4);
    put(REG_CTRL, 16'h000b);
    chk("alarm", alarm, 16'h1);
    rchk(REG_CTRL, 16'h0003);
    chk("mon", mon, 16'h0000);
    // One monitor bit per function 2 to 9, routed to an output device
    put(REG_OUT_ASSIGN, 16'h0005);
    for (int k = 2; k < NFUNC; k++) begin
      put(REG_NET_CMD, 16'h03ff ^ (16'h1 << k));
      chk("mon", mon, 16'h1 << k);
      chk("sout", sout, (k == 4) ? 16'h1 : 16'h0);
    end
    put(REG_NET_CMD, 16'h03ff);
    // Input-device mode, pins 2 and 3 unassigned and off
    put(REG_CTRL, 16'h0000);
    put(REG_IN_ASSIGN, 16'h0011);
    safety_io_model_i.pins(4'h2);
    cyc(4);
    chk("tss", tss, 16'h0);
    safety_io_model_i.fault(1'h1, 1'h0);
    cyc(4);
    safety_io_model_i.fault(1'h0, 1'h0);
    cyc(4);
    put(REG_CTRL, 16'h0008);
    chk("alarm", alarm, 16'h0);
    safety_io_model_i.all_on(4'h3);
    cyc(4);
    put(REG_CTRL, 16'h0008);
    chk("alarm", alarm, 16'h1);
    chk("tss", tss, 16'h1);
    safety_io_model_i.fault(1'h1, 1'h0);
    cyc(4);
    safety_io_model_i.fault(1'h0, 1'h0);
    cyc(4);
    safety_io_model_i.comm_pulse();
    cyc(5);
    chk("alarm", alarm, 16'h1);
    // Serious error stops everything until power returns
    put(REG_IN_ASSIGN, 16'h0511);
    rchk(REG_IN_ASSIGN, 16'h0511);
    chk("sout", sout, 16'h0001);
    safety_io_model_i.fault(1'h0, 1'h1);
    cyc(5);
    chk("mon", mon, 16'h0000);
    chk("sout", sout, 16'h0000);
    chk("dyn", dyn, 16'h1);
    rchk(REG_STATUS, 16'h0c00);
    safety_io_model_i.fault(1'h0, 1'h0);
    cyc(4);
    put(REG_CTRL, 16'h0008);
    chk("alarm", alarm, 16'h0);
    @(posedge clk) resetn <= 1'h0;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    cyc(2);
    chk("alarm", alarm, 16'h1);
    chk("tss", tss, 16'h1);
    conclude();
  end
endmodule : tb_safety_stop_coordinator
`default_nettype wire
